// ===== dv/pia_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module pia_core_model (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [1:0] ipl_set,
   input wire logic irq_req,
   input wire logic [20:0] irq_addr,
   output logic [1:0] core_ipl,
   output logic [20:0] fetch_addr
);
   // core fetches straight from the presented address, no table walk for fast ones
   always_ff @(posedge clk) begin
      if (!nrst) begin
         core_ipl <= 2'h0;
         fetch_addr <= 21'h000000;
      end else begin
         core_ipl <= ipl_set;
         if (irq_req) begin
            fetch_addr <= irq_addr;
         end
      end
   end
endmodule
`default_nettype wire

// ===== dv/prioritized_interrupt_arbiter_tb_top.sv
`include "pia_params.svh"
`timescale 1ns/1ps
`default_nettype none
module prioritized_interrupt_arbiter_tb_top;
   logic clk, nrst, ce, reg_wr, reg_rd, irq_req, irq_fast;
   logic [4:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata;
   logic [`PIA_N_SRC-1:0] irq_src;
   logic [1:0] ipl_set, core_ipl, irq_level;
   logic [`PIA_VEC_W-1:0] irq_vector;
   logic [`PIA_ADDR_W-1:0] irq_addr, fetch_addr;
   logic [15:0] prio_sh [0:8];
   int num_errors = 0;
   int checks = 0;
   int cyc = 0;
   pia_arbiter dut_u (.clk(clk), .nrst(nrst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_src(irq_src), .core_ipl(core_ipl),
      .irq_req(irq_req), .irq_vector(irq_vector), .irq_addr(irq_addr), .irq_fast(irq_fast),
      .irq_level(irq_level));
   pia_core_model core_u (.clk(clk), .nrst(nrst), .ipl_set(ipl_set), .irq_req(irq_req),
      .irq_addr(irq_addr), .core_ipl(core_ipl), .fetch_addr(fetch_addr));
   // ----------------------------------------
   // clock and hang guard
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // the whole run needs well under a thousand cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         num_errors = num_errors + 1;
         test_done();
      end
   end
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks = checks + 1;
      if (seen !== exp) begin
         num_errors = num_errors + 1;
         $display("CHECK FAILED t=%0t %s seen %0h exp %0h", $time, what, seen, exp);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [4:0] a, input logic [15:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp, "read");
   endtask
   task automatic set_prio(input int s, input logic [1:0] code);
      prio_sh[s/8][2*(s%8)+:2] = code;
      wr(5'(s/8), prio_sh[s/8]);
   endtask
   // outputs are registered, so let the inputs settle a few edges first
   task automatic exp_irq(input logic r, input logic [6:0] v, input logic [20:0] a, input logic f,
      input logic [1:0] l);
      repeat (3) @(posedge clk);
      #1;
      chk({irq_req, irq_fast, irq_level, irq_vector}, {r, f, l, v}, "irq");
      chk(irq_addr, a, "addr");
   endtask
   function automatic logic [20:0] ord(input int v);
      return 21'h001200 + 21'(2 * v);
   endfunction
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset_regs();
      rd(`PIA_OFS_VBASE, `PIA_VBASE_RST_LARGE);
      exp_irq(1'b0, 7'h00, 21'h000000, 1'b0, 2'h0);
      wr(`PIA_OFS_VBASE, 16'h0012);
      rd(`PIA_OFS_VBASE, 16'h0012);
      wr(5'h11, 16'hABCD);
      rd(5'h11, 16'h0000);
   endtask
   task automatic t_fixed();
      irq_src[1:0] <= 2'b11;
      exp_irq(1'b1, 7'h00, ord(0), 1'b0, `PIA_FIXED_LEVEL);
      irq_src[1:0] <= 2'b10;
      exp_irq(1'b1, 7'h01, ord(1), 1'b0, `PIA_FIXED_LEVEL);
      irq_src[1:0] <= 2'b00;
   endtask
   task automatic t_levels();
      irq_src[10] <= 1'b1;
      exp_irq(1'b0, 7'h00, 21'h000000, 1'b0, 2'h0);
      set_prio(10, 2'h2);
      exp_irq(1'b1, 7'd10, ord(10), 1'b0, 2'h1);
      irq_src[12] <= 1'b1;
      set_prio(12, 2'h2);
      exp_irq(1'b1, 7'd10, ord(10), 1'b0, 2'h1);
      set_prio(12, 2'h3);
      exp_irq(1'b1, 7'd12, ord(12), 1'b0, 2'h2);
      ipl_set <= 2'h3;
      exp_irq(1'b0, 7'h00, 21'h000000, 1'b0, 2'h0);
      ipl_set <= 2'h0;
   endtask
   task automatic t_fast();
      wr(`PIA_OFS_FM0, 16'd12);
      wr(`PIA_OFS_FVL0, 16'hBEEF);
      wr(`PIA_OFS_FVH0, 16'h0015);
      exp_irq(1'b1, 7'd12, 21'h15BEEF, 1'b1, 2'h2);
      chk(fetch_addr, 21'h15BEEF, "fetch");
      // both match registers name 12: pair 0 must still supply the address
      wr(`PIA_OFS_FM1, 16'd12);
      exp_irq(1'b1, 7'd12, 21'h15BEEF, 1'b1, 2'h2);
      set_prio(20, 2'h3);
      wr(`PIA_OFS_FM1, 16'd20);
      wr(`PIA_OFS_FVL1, 16'h1234);
      wr(`PIA_OFS_FVH1, 16'h000A);
      irq_src <= {45'h0, 1'b1, 20'h00000};
      exp_irq(1'b1, 7'd20, 21'h0A1234, 1'b1, 2'h2);
      rd(`PIA_OFS_STATUS, 16'hE014);
      set_prio(20, 2'h2);
      exp_irq(1'b1, 7'd20, ord(20), 1'b0, 2'h1);
      irq_src[20] <= 1'b0;
   endtask
   // enable low freezes outputs and drops writes; a mid-run reset restores defaults
   task automatic t_hold_reset();
      @(posedge clk);
      ce <= 1'b0;
      irq_src[0] <= 1'b1;
      exp_irq(1'b0, 7'h00, 21'h000000, 1'b0, 2'h0);
      wr(`PIA_OFS_VBASE, 16'h0040);
      ce <= 1'b1;
      exp_irq(1'b1, 7'h00, ord(0), 1'b0, `PIA_FIXED_LEVEL);
      rd(`PIA_OFS_VBASE, 16'h0012);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk({irq_req, irq_fast, irq_level}, 4'h0, "held in reset");
      nrst <= 1'b1;
      exp_irq(1'b1, 7'h00, 21'h000000, 1'b0, `PIA_FIXED_LEVEL);
      rd(`PIA_OFS_VBASE, `PIA_VBASE_RST_LARGE);
      rd(5'h01, 16'h0000);
      rd(`PIA_OFS_FM0, 16'h0000);
   endtask
   // ----------------------------------------
   // main sequence and verdict
   // ----------------------------------------
   task automatic test_done();
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      nrst = 1'b0;
      ce = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 5'h00;
      reg_wdata = 16'h0000;
      irq_src = '0;
      ipl_set = 2'h0;
      for (int i = 0; i < 9; i++) begin
         prio_sh[i] = 16'h0000;
      end
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      t_reset_regs();
      t_fixed();
      t_levels();
      t_fast();
      t_hold_reset();
      test_done();
   end
endmodule
`default_nettype wire

// ===== verilog/pia_arbiter.sv
`include "pia_params.svh"
`timescale 1ns/1ps
`default_nettype none
module pia_arbiter #(
   parameter bit SMALL_MEM = 1'b0,
   parameter logic [`PIA_N_SRC-1:0] FIXED_MASK = `PIA_FIXED_MASK
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic [4:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic [`PIA_N_SRC-1:0] irq_src,
   input wire logic [1:0] core_ipl,
   output logic irq_req,
   output logic [`PIA_VEC_W-1:0] irq_vector,
   output logic [`PIA_ADDR_W-1:0] irq_addr,
   output logic irq_fast,
   output logic [1:0] irq_level
);
   localparam int N = `PIA_N_SRC;
   localparam logic [15:0] VBASE_RST = SMALL_MEM ? `PIA_VBASE_RST_SMALL : `PIA_VBASE_RST_LARGE;

   pia_pkg::pia_state_t st_reg;
   pia_pkg::pia_state_t st_next;
   logic [3:0] lvl_found;
   logic [6:0] lvl_idx [4];
   logic [N-1:0] lvl_req [4];

   // ----------------------------------------
   // per-level request masks and encoders
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : gen_lvl
         pia_enc_if #(.N(N)) enc_bus();
         pia_level_enc #(.N(N)) u_enc (
            .bus(enc_bus.enc)
         );
         // level 3 holds only the fixed sources; disabled fields match no level
         for (genvar s = 0; s < N; s++) begin : gen_src
            if (g == 3) begin : gen_fix
               assign lvl_req[g][s] = irq_src[s] & FIXED_MASK[s];
            end else begin : gen_prog
               assign lvl_req[g][s] = irq_src[s] & ~FIXED_MASK[s]
                  & (st_reg.prio[2*s +: 2] == 2'(g + 1));
            end
         end
         assign enc_bus.req = lvl_req[g];
         assign lvl_found[g] = enc_bus.found;
         assign lvl_idx[g] = enc_bus.idx;
      end
   endgenerate

   // ----------------------------------------
   // winner selection
   // ----------------------------------------
   logic sel_found;
   logic [1:0] sel_lvl;
   logic [6:0] sel_vec;
   logic sel_ok;
   logic sel_fast0;
   logic sel_fast1;
   logic [`PIA_ADDR_W-1:0] base_addr;

   // scan lowest level first so the last hit, the highest level, always beats a lower vector
   always_comb begin
      sel_found = 1'b0;
      sel_lvl = 2'h0;
      sel_vec = 7'h00;
      for (int l = 0; l < 4; l++) begin
         if (lvl_found[l]) begin
            sel_found = 1'b1;
            sel_lvl = 2'(l);
            sel_vec = lvl_idx[l];
         end
      end
   end

   // fixed sources ignore the core's mask; others must reach it
   assign sel_ok = sel_found & ((sel_lvl == `PIA_FIXED_LEVEL) | (sel_lvl >= core_ipl));
   // compare against both match registers before the core ever sees it
   assign sel_fast0 = (sel_lvl == `PIA_FAST_LEVEL) & (sel_vec == st_reg.fm0);
   assign sel_fast1 = (sel_lvl == `PIA_FAST_LEVEL) & (sel_vec == st_reg.fm1);
   // two-word table entries: vector 0 lands on the base itself
   assign base_addr = {st_reg.vbase[12:0], 8'h00} + {13'h0000, sel_vec, 1'b0};

   // ----------------------------------------
   // register file and output state
   // ----------------------------------------
   always_comb begin
      st_next = st_reg;
      if (reg_wr) begin
         if (reg_addr <= `PIA_OFS_PRIO_LAST) begin
            st_next.prio[{reg_addr[3:0], 4'h0} +: 16] = reg_wdata;
         end else begin
            case (reg_addr)
               `PIA_OFS_VBASE: st_next.vbase = reg_wdata;
               `PIA_OFS_FM0: st_next.fm0 = reg_wdata[6:0];
               `PIA_OFS_FM1: st_next.fm1 = reg_wdata[6:0];
               `PIA_OFS_FVL0: st_next.fvl0 = reg_wdata;
               `PIA_OFS_FVH0: st_next.fvh0 = reg_wdata[4:0];
               `PIA_OFS_FVL1: st_next.fvl1 = reg_wdata;
               `PIA_OFS_FVH1: st_next.fvh1 = reg_wdata[4:0];
               default: ;
            endcase
         end
      end
      // read data live for exactly one cycle, zero otherwise
      st_next.rdat = 16'h0000;
      if (reg_rd) begin
         if (reg_addr <= `PIA_OFS_PRIO_LAST) begin
            st_next.rdat = st_reg.prio[{reg_addr[3:0], 4'h0} +: 16];
         end else begin
            case (reg_addr)
               `PIA_OFS_VBASE: st_next.rdat = st_reg.vbase;
               `PIA_OFS_FM0: st_next.rdat = {9'h000, st_reg.fm0};
               `PIA_OFS_FM1: st_next.rdat = {9'h000, st_reg.fm1};
               `PIA_OFS_FVL0: st_next.rdat = st_reg.fvl0;
               `PIA_OFS_FVH0: st_next.rdat = {11'h000, st_reg.fvh0};
               `PIA_OFS_FVL1: st_next.rdat = st_reg.fvl1;
               `PIA_OFS_FVH1: st_next.rdat = {11'h000, st_reg.fvh1};
               `PIA_OFS_STATUS: st_next.rdat = {st_reg.req, st_reg.fast, st_reg.lvl, 5'h00, st_reg.vec};
               default: st_next.rdat = 16'h0000;
            endcase
         end
      end
      // presented vector follows the arbitration every cycle
      st_next.req = sel_ok;
      st_next.lvl = sel_ok ? sel_lvl : 2'h0;
      st_next.vec = sel_ok ? sel_vec : 7'h00;
      st_next.fast = sel_ok & (sel_fast0 | sel_fast1);
      if (!sel_ok) begin
         st_next.addr = '0;
      end else if (sel_fast0) begin
         st_next.addr = {st_reg.fvh0, st_reg.fvl0};
      end else if (sel_fast1) begin
         st_next.addr = {st_reg.fvh1, st_reg.fvl1};
      end else begin
         st_next.addr = base_addr;
      end
   end

   // single register stage; the enable freezes everything
   always_ff @(posedge clk) begin
      if (!nrst) begin
         st_reg <= '0;
         st_reg.vbase <= VBASE_RST;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   assign reg_rdata = st_reg.rdat;
   assign irq_req = st_reg.req;
   assign irq_vector = st_reg.vec;
   assign irq_addr = st_reg.addr;
   assign irq_fast = st_reg.fast;
   assign irq_level = st_reg.lvl;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);

   // vectors below the winner, for the lowest-wins check
   logic [N-1:0] below_mask;
   assign below_mask = (N'(1) << sel_vec) - N'(1);

   chk_fast_is_l2: assert property (irq_fast |-> irq_req && irq_level == 2'h2)
      else $error("fast request not at level 2");
   chk_fast_matches: assert property (irq_fast |-> irq_vector == st_reg.fm0 || irq_vector == st_reg.fm1)
      else $error("fast request without a match");
   chk_fast_addr: assert property (ce && sel_ok && sel_fast0 |=> irq_fast && irq_addr == $past({st_reg.fvh0, st_reg.fvl0}))
      else $error("fast address not from pair 0");
   chk_base_addr: assert property (ce && sel_ok && !sel_fast0 && !sel_fast1
      |=> !irq_fast && irq_addr == {$past(st_reg.vbase[12:0]), 8'h00} + {13'h0000, irq_vector, 1'b0})
      else $error("ordinary address not offset from base");
   chk_lowest_wins: assert property (ce && sel_found |-> (lvl_req[sel_lvl] & below_mask) == '0)
      else $error("lower vector skipped");
   chk_level_order: assert property (ce && sel_found && sel_lvl != 2'h3 |-> lvl_found[3:1] >> sel_lvl == 3'h0)
      else $error("higher level request ignored");
   chk_disabled_quiet: assert property (ce && sel_found && !FIXED_MASK[sel_vec]
      |-> st_reg.prio[{sel_vec, 1'b0} +: 2] != `PIA_FLD_DISABLED)
      else $error("disabled source selected");
   chk_ipl_gate: assert property (ce && sel_found && sel_lvl != 2'h3 && sel_lvl < core_ipl |=> !irq_req)
      else $error("request below core mask");
   chk_reset_base: assert property (!$past(nrst) |-> st_reg.vbase == VBASE_RST)
      else $error("vector base reset wrong");
   chk_read_slot: assert property (ce && reg_rd && reg_addr == `PIA_OFS_VBASE
      |=> reg_rdata == $past(st_reg.vbase) ##1 (!$past(ce) || $past(reg_rd) || reg_rdata == 16'h0000))
      else $error("read data not in the following cycle only");
   // enable low must hold every register, writes and arbitration included
   chk_freeze_hold: assert property (!ce |=> $stable(st_reg))
      else $error("state moved while enable low");
   chk_fast_pair1: assert property (ce && sel_ok && !sel_fast0 && sel_fast1
      |=> irq_fast && irq_addr == $past({st_reg.fvh1, st_reg.fvl1}))
      else $error("fast address not from pair 1");
   chk_fixed_unmasked: assert property (ce && lvl_found[3] |=> irq_req && irq_level == 2'h3)
      else $error("fixed source not presented");
endmodule
`default_nettype wire

// ===== verilog/pia_enc_if.sv
`timescale 1ns/1ps
`default_nettype none
// one level's request vector and its encoded winner
interface pia_enc_if #(parameter int N = 66);
   logic [N-1:0] req;
   logic found;
   logic [6:0] idx;
   modport enc (input req, output found, output idx);
   modport user (output req, input found, input idx);
endinterface
`default_nettype wire

// ===== verilog/pia_level_enc.sv
`timescale 1ns/1ps
`default_nettype none
module pia_level_enc #(
   parameter int N = 66
) (
   pia_enc_if.enc bus
);
   // ----------------------------------------
   // lowest index wins: scan downward so the last hit is the lowest
   // ----------------------------------------
   always_comb begin
      bus.found = 1'b0;
      bus.idx = 7'h00;
      for (int i = N - 1; i >= 0; i--) begin
         if (bus.req[i]) begin
            bus.found = 1'b1;
            bus.idx = 7'(i);
         end
      end
   end
endmodule
`default_nettype wire

// ===== verilog/pia_params.svh
`ifndef PIA_PARAMS_SVH
`define PIA_PARAMS_SVH
// ----------------------------------------
// sizes
// ----------------------------------------
`define PIA_N_SRC 66
`define PIA_N_PRIO_REGS 9
`define PIA_VEC_W 7
`define PIA_ADDR_W 21
// ----------------------------------------
// register offsets (word index on the register port)
// ----------------------------------------
`define PIA_OFS_PRIO0 5'h00
`define PIA_OFS_PRIO_LAST 5'h08
`define PIA_OFS_VBASE 5'h09
`define PIA_OFS_FM0 5'h0A
`define PIA_OFS_FM1 5'h0B
`define PIA_OFS_FVL0 5'h0C
`define PIA_OFS_FVH0 5'h0D
`define PIA_OFS_FVL1 5'h0E
`define PIA_OFS_FVH1 5'h0F
`define PIA_OFS_STATUS 5'h10
// ----------------------------------------
// field positions and codes
// ----------------------------------------
`define PIA_FLD_DISABLED 2'h0
`define PIA_FAST_LEVEL 2'h2
`define PIA_FIXED_LEVEL 2'h3
`define PIA_STAT_REQ_BIT 15
`define PIA_STAT_FAST_BIT 14
// ----------------------------------------
// reset values
// ----------------------------------------
`define PIA_VBASE_RST_LARGE 16'h0000
`define PIA_VBASE_RST_SMALL 16'h0020
`define PIA_FIXED_MASK 66'h0_0000_0000_0000_0003
`endif

// ===== verilog/pia_pkg.sv
`include "pia_params.svh"
`default_nettype none
package pia_pkg;
   // whole register and output state of the arbiter
   typedef struct packed {
      logic [`PIA_N_PRIO_REGS*16-1:0] prio;
      logic [15:0] vbase;
      logic [`PIA_VEC_W-1:0] fm0;
      logic [`PIA_VEC_W-1:0] fm1;
      logic [15:0] fvl0;
      logic [4:0] fvh0;
      logic [15:0] fvl1;
      logic [4:0] fvh1;
      logic [15:0] rdat;
      logic req;
      logic fast;
      logic [1:0] lvl;
      logic [`PIA_VEC_W-1:0] vec;
      logic [`PIA_ADDR_W-1:0] addr;
   } pia_state_t;
endpackage
`default_nettype wire
